// *** core/ehb_pkg.sv ***
// Shared constants and types for the event history buffer and its reader
package ehb_pkg;
  // ****************************************************
  // Sizes
  // ****************************************************
  localparam int          DEPTH      = 10;
  localparam int          REC_WORDS  = 5;
  localparam int          AW         = 16;
  localparam int          DW         = 16;
  localparam int          IDXW       = 4;
  localparam int          WSELW      = 3;
  localparam int          CNTW       = 8;
  localparam logic [7:0]  FC_READ_IN = 8'h04;
  localparam logic [15:0] UNUSED_VAL = 16'h8000;
  localparam logic [15:0] BASE_ADDR  = 16'h0000;
  // ****************************************************
  // Millisecond complement word layout
  // ****************************************************
  localparam int          MS_LSB     = 0;
  localparam int          MS_W       = 10;
  localparam int          EXT_SYNC_B = 12;
  localparam int          INT_SYNC_B = 13;
  localparam int          DATE_SET_B = 14;
  // ****************************************************
  // Access classes
  // ****************************************************
  typedef enum logic [2:0] {
    EHB_ACC_READ, EHB_ACC_WRITE, EHB_ACC_RW, EHB_ACC_COMMAND_READABLE, EHB_ACC_COMMAND_WRITABLE
  } ehb_access_t;
  typedef struct packed {
    logic [31:0] seconds;
    logic [15:0] ms_word;
    logic [15:0] code;
  } ehb_rec_t;
  // Register number seen by the client for a frame address
  function automatic logic [16:0] ehb_reg_number(input logic [AW-1:0] addr);
    ehb_reg_number = {1'b0, addr} + 17'h00001;
  endfunction
  // Word k of a record, most significant word of the 32-bit count first
  function automatic logic [DW-1:0] ehb_word(input ehb_rec_t rec, input logic [WSELW-1:0] k);
    case (k)
      3'h0:    ehb_word = rec.seconds[31:16];
      3'h1:    ehb_word = rec.seconds[15:0];
      3'h2:    ehb_word = rec.ms_word;
      3'h3:    ehb_word = rec.code;
      default: ehb_word = 16'h0000;
    endcase
  endfunction
endpackage

// *** core/ehb_if.sv ***
// Link between the history buffer and its reading client
`timescale 1ns/1ps
`default_nettype none
interface ehb_if;
  logic        req_valid;
  logic [7:0]  req_func;
  logic [15:0] req_addr;
  logic [7:0]  req_count;
  logic        req_ready;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  logic        rsp_last;
  logic        rsp_error;
  modport device (input req_valid, req_func, req_addr, req_count,
                  output req_ready, rsp_valid, rsp_data, rsp_last, rsp_error);
  modport client (output req_valid, req_func, req_addr, req_count,
                  input req_ready, rsp_valid, rsp_data, rsp_last, rsp_error);
endinterface
`default_nettype wire

// *** core/ehb_device.sv ***
// Event history store answering read-input-register requests
// What this block does
// [R1] Stamp each record with seconds and millisecond word
// [R2] Full history drops oldest, new record on top
// [R3] Records ordered newest first
// [R4] Each event shifts all records down one
// [R5] Function code 4 reads history records
// [R6] m times n words, newest record first
// [R7] Unused history words read as 0x8000
// [R8] Register number is address plus one
// [R9] Five access classes: read, write, both, command
// [R10] Scaled values stored multiplied by factor
// [R11] Multiword values sent most significant word first
// [R12] Multiword integers built from unsigned 16-bit words
// [R13] Floats use IEEE single precision
// [R14] Text strings use one byte per character
// [R15] Ten records of five words each
// [R16] Millisecond word holds ms and sync flags
// [R17] Reset marks every slot unused
`timescale 1ns/1ps
`default_nettype none
module ehb_device (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Event capture
  input  wire logic        i_evt_valid,
  input  wire logic [15:0] i_evt_code,
  input  wire logic [31:0] i_seconds_epoch_timestamp,
  input  wire logic [9:0]  i_evt_ms,
  input  wire logic        i_ext_sync,
  input  wire logic        i_int_sync,
  input  wire logic        i_date_set,
  // Status
  output logic [3:0]       o_rec_count,
  output ehb_pkg::ehb_access_t o_access,
  // Client link
  ehb_if.device            link
);
  // ****************************************************
  // Store
  // ****************************************************
  typedef enum {EHB_IDLE, EHB_SEND} ehb_state_t;
  ehb_pkg::ehb_rec_t             hist [ehb_pkg::DEPTH];
  ehb_pkg::ehb_rec_t             next_hist [ehb_pkg::DEPTH];
  logic [ehb_pkg::DEPTH-1:0]     used;
  logic [ehb_pkg::DEPTH-1:0]     next_used;
  logic [3:0]                    next_rec_count;
  ehb_pkg::ehb_rec_t             new_rec;
  ehb_state_t                    state, next_state;
  logic [ehb_pkg::IDXW-1:0]      rec_idx;
  logic [ehb_pkg::IDXW-1:0]      next_rec_idx;
  logic [ehb_pkg::WSELW-1:0]     wsel;
  logic [ehb_pkg::WSELW-1:0]     next_wsel;
  logic [ehb_pkg::CNTW-1:0]      left;
  logic [ehb_pkg::CNTW-1:0]      next_left;
  logic                          rdy, next_rdy;
  logic                          vld, next_vld;
  logic                          lst, next_lst;
  logic                          err, next_err;
  logic [15:0]                   dat;
  logic [15:0]                   next_dat;
  logic [16:0]                   regnum;
  logic [15:0]                   start_rec;
  always_comb begin
    new_rec         = '0;
    new_rec.seconds = i_seconds_epoch_timestamp; // R1
    new_rec.ms_word[ehb_pkg::MS_LSB +: ehb_pkg::MS_W] = i_evt_ms; // R16
    new_rec.ms_word[ehb_pkg::EXT_SYNC_B] = i_ext_sync; // R16
    new_rec.ms_word[ehb_pkg::INT_SYNC_B] = i_int_sync; // R16
    new_rec.ms_word[ehb_pkg::DATE_SET_B] = i_date_set; // R16
    new_rec.code    = i_evt_code; // R10 R13 R14
  end
  always_comb begin
    for (int k = 0; k < ehb_pkg::DEPTH; k++) begin
      next_hist[k] = hist[k];
    end
    next_used      = used;
    next_rec_count = o_rec_count;
    if (i_evt_valid) begin
      for (int k = ehb_pkg::DEPTH-1; k > 0; k--) begin
        next_hist[k] = hist[k-1]; // R4
      end
      next_hist[0] = new_rec; // R2
      next_used    = {used[ehb_pkg::DEPTH-2:0], 1'b1}; // R3
      if (o_rec_count != 4'(ehb_pkg::DEPTH)) begin
        next_rec_count = o_rec_count + 4'h1;
      end
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      used        <= '0; // R17
      o_rec_count <= 4'h0;
      for (int k = 0; k < ehb_pkg::DEPTH; k++) begin
        hist[k] <= '0;
      end
    end else begin
      used        <= next_used;
      o_rec_count <= next_rec_count;
      for (int k = 0; k < ehb_pkg::DEPTH; k++) begin
        hist[k] <= next_hist[k];
      end
    end
  end
  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [ehb_pkg::IDXW-1:0] clamp_rec(input logic [15:0] r);
    if (r >= 16'(ehb_pkg::DEPTH)) begin
      clamp_rec = 4'(ehb_pkg::DEPTH);
    end else begin
      clamp_rec = 4'(r);
    end
  endfunction
  // ****************************************************
  // Read engine
  // ****************************************************
  assign regnum = ehb_pkg::ehb_reg_number(link.req_addr); // R8
  assign start_rec = 16'((link.req_addr - ehb_pkg::BASE_ADDR) / ehb_pkg::REC_WORDS); // R15
  always_comb begin
    next_state   = state;
    next_rec_idx = rec_idx;
    next_wsel    = wsel;
    next_left    = left;
    next_rdy     = rdy;
    next_vld     = 1'b0;
    next_lst     = 1'b0;
    next_err     = 1'b0;
    next_dat     = dat;
    case (state)
      EHB_IDLE: begin
        next_rdy = 1'b1;
        if (link.req_valid && rdy) begin
          next_rdy = 1'b0;
          if (link.req_func != ehb_pkg::FC_READ_IN || link.req_count == 8'h00 ||
              regnum[15:0] <= ehb_pkg::BASE_ADDR) begin // R5
            next_vld = 1'b1;
            next_lst = 1'b1;
            next_err = 1'b1;
            next_dat = 16'h0000;
            next_state = EHB_IDLE;
          end else begin
            next_rec_idx = clamp_rec(start_rec); // R7 R15
            next_wsel    = 3'((link.req_addr - ehb_pkg::BASE_ADDR) % ehb_pkg::REC_WORDS);
            next_left    = link.req_count;
            next_state   = EHB_SEND;
          end
        end
      end
      EHB_SEND: begin
        next_vld = 1'b1;
        if (rec_idx < 4'(ehb_pkg::DEPTH) && used[rec_idx]) begin
          next_dat = ehb_pkg::ehb_word(hist[rec_idx], wsel); // R6 R11 R12
        end else begin
          next_dat = ehb_pkg::UNUSED_VAL; // R7
        end
        next_left = left - 8'h01;
        if (wsel == 3'(ehb_pkg::REC_WORDS-1)) begin
          next_wsel    = 3'h0;
          next_rec_idx = clamp_rec(16'(rec_idx) + 16'h0001); // R6
        end else begin
          next_wsel = wsel + 3'h1;
        end
        if (left == 8'h01) begin
          next_lst   = 1'b1;
          next_state = EHB_IDLE;
        end
      end
      default: next_state = EHB_IDLE;
    endcase
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state   <= EHB_IDLE;
      rec_idx <= '0;
      wsel    <= '0;
      left    <= '0;
      rdy     <= 1'b0;
      vld     <= 1'b0;
      lst     <= 1'b0;
      err     <= 1'b0;
      dat     <= 16'h0000;
      o_access <= ehb_pkg::EHB_ACC_READ; // R9
    end else begin
      state   <= next_state;
      rec_idx <= next_rec_idx;
      wsel    <= next_wsel;
      left    <= next_left;
      rdy     <= next_rdy;
      vld     <= next_vld;
      lst     <= next_lst;
      err     <= next_err;
      dat     <= next_dat;
      o_access <= ehb_pkg::EHB_ACC_READ; // R9
    end
  end
  // ****************************************************
  // Response outputs
  // ****************************************************
  assign link.req_ready = rdy;
  assign link.rsp_valid = vld;
  assign link.rsp_last  = lst;
  assign link.rsp_error = err;
  assign link.rsp_data  = dat;
endmodule
`default_nettype wire

// *** core/ehb_client.sv ***
// Client end that issues history reads and passes the words back
`timescale 1ns/1ps
`default_nettype none
module ehb_client (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // User request
  input  wire logic        i_start,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_count,
  output logic             o_busy,
  // User answer
  output logic             o_word_valid,
  output logic [15:0]      o_word,
  output logic             o_done,
  output logic             o_error,
  // Device link
  ehb_if.client            link
);
  // ****************************************************
  // Request sequencer
  // ****************************************************
  typedef enum {EHC_IDLE, EHC_REQ, EHC_WAIT} ehb_cstate_t;
  ehb_cstate_t state, next_state;
  logic        rv, next_rv, next_busy, next_wv, next_done, next_error;
  logic [15:0] addr, next_addr, next_word;
  logic [7:0]  cnt, next_cnt;
  always_comb begin
    next_state = state;
    next_rv    = rv;
    next_addr  = addr;
    next_cnt   = cnt;
    next_busy  = o_busy;
    next_wv    = 1'b0;
    next_word  = o_word;
    next_done  = 1'b0;
    next_error = o_error;
    case (state)
      EHC_IDLE: begin
        if (i_start) begin
          next_addr  = i_addr; // R8
          next_cnt   = i_count; // R6
          next_rv    = 1'b1;
          next_busy  = 1'b1;
          next_error = 1'b0;
          next_state = EHC_REQ;
        end
      end
      EHC_REQ: begin
        if (link.req_ready) begin
          next_rv    = 1'b0;
          next_state = EHC_WAIT;
        end
      end
      EHC_WAIT: begin
        if (link.rsp_valid) begin
          next_wv   = !link.rsp_error;
          next_word = link.rsp_data; // R12
          if (link.rsp_error) begin
            next_error = 1'b1;
          end
          if (link.rsp_last) begin
            next_done  = 1'b1;
            next_busy  = 1'b0;
            next_state = EHC_IDLE;
          end
        end
      end
      default: next_state = EHC_IDLE;
    endcase
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state        <= EHC_IDLE;
      rv           <= 1'b0;
      addr         <= 16'h0000;
      cnt          <= 8'h00;
      o_busy       <= 1'b0;
      o_word_valid <= 1'b0;
      o_word       <= 16'h0000;
      o_done       <= 1'b0;
      o_error      <= 1'b0;
    end else begin
      state        <= next_state;
      rv           <= next_rv;
      addr         <= next_addr;
      cnt          <= next_cnt;
      o_busy       <= next_busy;
      o_word_valid <= next_wv;
      o_word       <= next_word;
      o_done       <= next_done;
      o_error      <= next_error;
    end
  end
  assign link.req_valid = rv;
  assign link.req_func  = ehb_pkg::FC_READ_IN; // R5
  assign link.req_addr  = addr;
  assign link.req_count = cnt;
endmodule
`default_nettype wire

// *** testbench/ehb_link_monitor.sv ***
// Protocol checker for the history buffer link
`timescale 1ns/1ps
`default_nettype none
module ehb_link_monitor (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Link signals
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_func,
  input  wire logic [15:0] req_addr,
  input  wire logic [7:0]  req_count,
  input  wire logic        req_ready,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data,
  input  wire logic        rsp_last,
  input  wire logic        rsp_error
);
  logic [16:0] pos;
  logic [7:0]  want;
  logic [7:0]  seen;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pos  <= 17'h00000;
      want <= 8'h00;
      seen <= 8'h00;
    end else if (req_valid && req_ready) begin
      pos  <= {1'b0, req_addr};
      want <= req_count;
      seen <= 8'h00;
    end else if (rsp_valid) begin
      pos  <= pos + 17'h00001;
      seen <= seen + 8'h01;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_take; req_valid && req_ready; endsequence
  sequence s_word; rsp_valid && !rsp_error; endsequence
  func_code_a: assert property (req_valid |-> req_func == 8'h04)
    else $error("request with wrong function code");
  req_hold_a: assert property (req_valid && !req_ready |=> req_valid && $stable(req_addr) && $stable(req_count))
    else $error("request dropped or changed before taken");
  first_word_a: assert property (s_take ##0 (req_count != 8'h00) |-> ##2 s_word)
    else $error("first word not two cycles after take");
  refuse_a: assert property (s_take ##0 (req_count == 8'h00) |=>
    rsp_valid && rsp_error && rsp_last && rsp_data == 16'h0000 && !req_ready ##1 req_ready)
    else $error("zero count not refused");
  ready_drop_a: assert property (s_take ##0 (req_count != 8'h00) |=> !req_ready [*2])
    else $error("ready back too early");
  burst_run_a: assert property (s_word ##0 !rsp_last |=> s_word)
    else $error("gap in answer words");
  word_count_a: assert property (s_word ##0 rsp_last |-> seen + 8'h01 == want)
    else $error("answer length differs from count");
  unused_word_a: assert property (s_word ##0 (pos >= 17'h00032) |-> rsp_data == 16'h8000)
    else $error("word past the store not unused pattern");
  ready_back_a: assert property (rsp_valid && rsp_last |-> ##[1:3] req_ready)
    else $error("ready not restored after answer");
endmodule
`default_nettype wire

// *** testbench/tb_event_history_buffer.sv ***
// Self-checking bench for the history buffer with both ends joined
`timescale 1ns/1ps
`default_nettype none
module tb_event_history_buffer;
  logic                 i_mclk;
  logic                 i_rst;
  logic                 evt_valid;
  logic [15:0]          evt_code;
  logic [31:0]          evt_sec;
  logic [9:0]           evt_ms;
  logic [2:0]           evt_flags;
  logic                 start;
  logic [15:0]          addr;
  logic [7:0]           count;
  logic                 busy;
  logic                 word_valid;
  logic [15:0]          word;
  logic                 done;
  logic                 err;
  logic [3:0]           rec_count;
  ehb_pkg::ehb_access_t access;
  logic [63:0]          model[$];
  int                   n_errors;
  int                   cmp_count;
  ehb_if lnk ();
  ehb_device ehb_device_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_evt_valid(evt_valid), .i_evt_code(evt_code),
    .i_seconds_epoch_timestamp(evt_sec), .i_evt_ms(evt_ms), .i_ext_sync(evt_flags[0]), .i_int_sync(evt_flags[1]),
    .i_date_set(evt_flags[2]), .o_rec_count(rec_count), .o_access(access), .link(lnk.device));
  ehb_client ehb_client_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_start(start), .i_addr(addr), .i_count(count),
    .o_busy(busy), .o_word_valid(word_valid), .o_word(word), .o_done(done), .o_error(err), .link(lnk.client));
  ehb_link_monitor ehb_link_monitor_i (.i_mclk(i_mclk), .i_rst(i_rst), .req_valid(lnk.req_valid),
    .req_func(lnk.req_func), .req_addr(lnk.req_addr), .req_count(lnk.req_count), .req_ready(lnk.req_ready),
    .rsp_valid(lnk.rsp_valid), .rsp_data(lnk.rsp_data), .rsp_last(lnk.rsp_last), .rsp_error(lnk.rsp_error));
  // ****************************************************
  // Helpers
  // ****************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] exp_word(input int a);
    logic [63:0] r;
    if (a / 5 >= model.size()) return 16'h8000;
    r = model[a / 5];
    case (a % 5)
      0: return r[63:48];
      1: return r[47:32];
      2: return r[31:16];
      3: return r[15:0];
      default: return 16'h0000;
    endcase
  endfunction
  task automatic push(input int n);
    for (int k = 0; k < n; k++) begin
      evt_valid = 1'b1;
      evt_code  = 16'($urandom);
      evt_sec   = $urandom;
      evt_ms    = 10'($urandom_range(999));
      evt_flags = 3'($urandom);
      model.push_front({evt_sec, 1'b0, evt_flags, 2'b00, evt_ms, evt_code});
      if (model.size() > 10) void'(model.pop_back());
      @(posedge i_mclk) #10;
    end
    evt_valid = 1'b0;
    @(posedge i_mclk) #10;
    check(16'(rec_count), 16'(model.size()));
    check(16'(access), 16'(ehb_pkg::EHB_ACC_READ));
  endtask
  task automatic rd(input int a, input int n);
    int got;
    got = 0;
    for (int t = 0; t < 50 && busy !== 1'b0; t++) @(posedge i_mclk) #10;
    check(16'(busy), 16'h0000);
    start = 1'b1;
    addr  = 16'(a);
    count = 8'(n);
    @(posedge i_mclk) #10;
    start = 1'b0;
    for (int t = 0; t < 200 && done !== 1'b1; t++) begin
      @(posedge i_mclk) #10;
      if (word_valid === 1'b1 && n != 0) begin
        check(word, exp_word(a + got));
        got++;
      end
    end
    check(16'(done), 16'h0001);
    check(16'(got), 16'(n));
    check(16'(err), 16'(n == 0));
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ****************************************************
  // Clock, watchdog and tests
  // ****************************************************
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_errors++;
    finish_test();
  end
  initial begin
    i_rst     = 1'b1;
    evt_valid = 1'b0;
    evt_code  = 16'h0000;
    evt_sec   = 32'h00000000;
    evt_ms    = 10'h000;
    evt_flags = 3'h0;
    start     = 1'b0;
    addr      = 16'h0000;
    count     = 8'h00;
    void'($urandom(32'h8b14abd4));
    repeat (20) @(posedge i_mclk);
    #10 i_rst = 1'b0;
    rd(0, 50);
    $display("test reset done");
    push(3);
    rd(0, 15);
    rd(48, 4);
    $display("test fill done");
    push(12);
    rd(0, 50);
    rd(47, 5);
    $display("test overflow done");
    rd(3, 0);
    rd(7, 2);
    $display("test refuse done");
    i_rst = 1'b1;
    repeat (2) @(posedge i_mclk) #10;
    i_rst = 1'b0;
    model.delete();
    check(16'(rec_count), 16'h0000);
    rd(0, 50);
    push(4);
    $display("test second reset done");
    for (int k = 0; k < 6; k++) rd($urandom_range(59), $urandom_range(12, 1));
    $display("test random done");
    finish_test();
  end
endmodule
`default_nettype wire
